// ---- tmr_defs.svh ----
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ==========================================================
// register offsets (word index on the register port)
`define TMR_OFS_CTRL    3'h0
`define TMR_OFS_COUNT   3'h1
`define TMR_OFS_CMP     3'h2
`define TMR_OFS_STATUS  3'h3

// ==========================================================
// control register fields
`define TMR_CTRL_FORCE  7
`define TMR_CTRL_WAVE0  6
`define TMR_CTRL_ACT1   5
`define TMR_CTRL_ACT0   4
`define TMR_CTRL_WAVE1  3
`define TMR_CTRL_CS_HI  2
`define TMR_CTRL_CS_LO  0

// status register fields (write one to clear the flags)
`define TMR_STAT_OVF    0
`define TMR_STAT_CMPF   1
`define TMR_STAT_OCS    2

// ==========================================================
// counter extremes and reset values
`define TMR_BOTTOM      8'h00
`define TMR_MAX         8'hFF
`define TMR_RST_BYTE    8'h00
`define TMR_PRE_W       10

`endif

// ---- tmr_pkg.sv ----
package tmr_pkg;

    // wave mode select, {upper bit, lower bit}
    typedef enum logic [1:0] {
        TMR_WAVE_NORMAL,
        TMR_WAVE_PHASE,
        TMR_WAVE_CLEAR_ON_MATCH,
        TMR_WAVE_FAST_PWM
    } tmr_wave_e;

    typedef struct packed {
        logic [7:0] count_value;
        logic [7:0] compare_value;      // value used by the comparator
        logic [7:0] compare_buf;        // software side of the double buffer
        tmr_wave_e  wave_mode_select;
        logic [1:0] output_action_select;
        logic [2:0] clock_select;
        logic [9:0] prescale;
        logic       overflow_flag;
        logic       compare_flag;
        logic       compare_output_state;
        logic       match_block;
        logic [7:0] rdata;
        logic       pin_out;
        logic       pin_oe;
    } tmr_state_s;

endpackage

// ---- tmr_wave.sv ----
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "tmr_defs.svh"
// Functional notes
// - reset clears the compare output state to zero.
// - nonzero action select drives pin value from output state; direction stays external.
// - pin override depends only on action select, not wave mode.
// - action select zero leaves output state unchanged at matches.
// - new action applies at next match; force strobe applies it at once in non-PWM.
// - counting sequence follows wave mode only, never action select.
// - normal mode always increments and wraps 0xFF to 0x00.
// - normal mode sets overflow flag as count becomes zero; counting never clears it.
// - normal mode accepts count writes any time.
// - clear-on-match mode clears count when it equals compare value.
// - clear-on-match compare writes unbuffered; value below count wraps through 0xFF first.
// - clear-on-match with action 1 toggles output state every match.
// - toggle frequency is clock over 2, prescale and compare plus one.
// - clear-on-match sets overflow flag as count wraps 0xFF to 0x00 without a match; a match at 0xFF clears count with no flag.
// - fast PWM counts bottom to max, then clears to bottom next tick.
// - fast PWM sets overflow flag each time count reaches max.
// - fast PWM action 2 clears on match, sets at bottom; action 3 opposite.
// - fast PWM period is 256 timer clocks.
// - fast PWM compare at bottom gives spike; at max gives constant level.
// - timer clock is I/O clock divided by 1, 8, 64, 256 or 1024.
// - compare value double buffered in PWM modes, immediate otherwise.
// - forced compare updates output state only, no flag, no counter change.
// - non-PWM actions: 1 toggles, 2 clears, 3 sets output state.
// - compare flag is set the timer cycle after count equals compare value.

module tmr_wave
    import tmr_pkg::*;
#(
    parameter int ADDR_W = 3
) (
    input  wire logic              core_clk_i,     // 40 MHz system clock
    input  wire logic              reset_i,        // synchronous, active high
    input  wire logic              core_ce_i,      // low freezes all state
    input  wire logic [ADDR_W-1:0] addr_i,         // register index
    input  wire logic [7:0]        wdata_i,        // write data
    input  wire logic              wr_i,           // write strobe
    input  wire logic              rd_i,           // read strobe
    output logic      [7:0]        rdata_o,        // read data, cycle after rd_i
    input  wire logic              port_value_i,   // ordinary port output value
    input  wire logic              compare_pin_direction_i, // 1 = pin is output
    output logic                   pin_out_o,      // pin output value
    output logic                   pin_oe_o        // pin output enable
);

    tmr_state_s s;
    tmr_state_s next_s;

    // ==========================================================
    // decoded helpers
    logic       tick;
    logic       pwm_mode;
    logic       match;
    logic       count_wr;
    logic [9:0] pre_mask;

    // prescale mask: tick when the masked bits of the free counter are all ones
    always_comb begin
        unique case (s.clock_select)
            3'd1:    pre_mask = 10'h000;           // divide by 1
            3'd2:    pre_mask = 10'h007;           // divide by 8
            3'd3:    pre_mask = 10'h03F;           // divide by 64
            3'd4:    pre_mask = 10'h0FF;           // divide by 256
            3'd5:    pre_mask = 10'h3FF;           // divide by 1024
            default: pre_mask = 10'h000;
        endcase
    end

    // timer clock enable; select 0 and the unused codes stop the timer
    assign tick = core_ce_i && (s.clock_select inside {3'd1, 3'd2, 3'd3, 3'd4, 3'd5})
                  && ((s.prescale & pre_mask) == pre_mask);
    assign pwm_mode = s.wave_mode_select[0];
    assign match    = (s.count_value == s.compare_value) && !s.match_block;
    assign count_wr = wr_i && (addr_i == `TMR_OFS_COUNT);

    // ==========================================================
    // next state
    always_comb begin
        logic       force_hit;
        logic [1:0] force_act;
        force_hit = 1'b0;
        force_act = 2'b00;
        next_s = s;
        next_s.prescale = s.prescale + 10'h001;

        // write-one clears go first, so a flag set by this same tick wins
        if (core_ce_i && wr_i && addr_i == `TMR_OFS_STATUS) begin
            if (wdata_i[`TMR_STAT_OVF])
                next_s.overflow_flag = 1'b0;
            if (wdata_i[`TMR_STAT_CMPF])
                next_s.compare_flag = 1'b0;
        end

        // counting sequence, chosen by wave mode alone
        if (tick) begin
            next_s.match_block = 1'b0;
            unique case (s.wave_mode_select)
                TMR_WAVE_CLEAR_ON_MATCH: begin
                    // unbuffered top: a top below count means a full wrap
                    if (match)
                        next_s.count_value = `TMR_BOTTOM;
                    else
                        next_s.count_value = s.count_value + 8'h01;
                    if (!match && s.count_value == `TMR_MAX)
                        next_s.overflow_flag = 1'b1;
                    // toggle every match: period 2*(1+top) ticks
                    if (match) begin
                        unique case (s.output_action_select)
                            2'd1: next_s.compare_output_state = !s.compare_output_state;
                            2'd2: next_s.compare_output_state = 1'b0;
                            2'd3: next_s.compare_output_state = 1'b1;
                            default: ;
                        endcase
                    end
                end
                TMR_WAVE_FAST_PWM: begin
                    // single slope over 256 ticks, max then bottom
                    next_s.count_value = s.count_value + 8'h01;
                    if (s.count_value == `TMR_MAX - 8'h01)
                        next_s.overflow_flag = 1'b1;
                    if (s.count_value == `TMR_MAX)
                        next_s.compare_value = s.compare_buf;
                    if (match) begin
                        unique case (s.output_action_select)
                            2'd1: next_s.compare_output_state = !s.compare_output_state;
                            2'd2: next_s.compare_output_state = 1'b0;
                            2'd3: next_s.compare_output_state = 1'b1;
                            default: ;
                        endcase
                    end
                    // bottom action wins at max, so compare at max is a
                    // constant level and compare at bottom a one-tick spike
                    if (s.count_value == `TMR_MAX) begin
                        unique case (s.output_action_select)
                            2'd2: next_s.compare_output_state = 1'b1;
                            2'd3: next_s.compare_output_state = 1'b0;
                            default: ;
                        endcase
                    end
                end
                default: begin
                    // normal mode; the unsupported dual-slope code counts the same way but takes no match action
                    next_s.count_value = s.count_value + 8'h01;
                    if (s.count_value == `TMR_MAX) begin
                        next_s.overflow_flag = 1'b1;
                        if (s.wave_mode_select == TMR_WAVE_PHASE)
                            next_s.compare_value = s.compare_buf;
                    end
                    if (match && s.wave_mode_select == TMR_WAVE_NORMAL) begin
                        unique case (s.output_action_select)
                            2'd1: next_s.compare_output_state = !s.compare_output_state;
                            2'd2: next_s.compare_output_state = 1'b0;
                            2'd3: next_s.compare_output_state = 1'b1;
                            default: ;
                        endcase
                    end
                end
            endcase
            if (match)
                next_s.compare_flag = 1'b1;
        end

        // register writes; a count write overrides counting and blocks
        // the match of the next timer cycle
        if (core_ce_i && wr_i) begin
            unique case (addr_i)
                `TMR_OFS_CTRL: begin
                    // new action takes effect from the next match on
                    next_s.wave_mode_select = tmr_wave_e'({wdata_i[`TMR_CTRL_WAVE1], wdata_i[`TMR_CTRL_WAVE0]});
                    next_s.output_action_select = wdata_i[`TMR_CTRL_ACT1:`TMR_CTRL_ACT0];
                    next_s.clock_select = wdata_i[`TMR_CTRL_CS_HI:`TMR_CTRL_CS_LO];
                    force_hit = wdata_i[`TMR_CTRL_FORCE] && !wdata_i[`TMR_CTRL_WAVE0];
                    force_act = wdata_i[`TMR_CTRL_ACT1:`TMR_CTRL_ACT0];
                end
                `TMR_OFS_COUNT: begin
                    next_s.count_value = wdata_i;
                    next_s.match_block = 1'b1;
                end
                `TMR_OFS_CMP: begin
                    next_s.compare_buf = wdata_i;
                    if (!pwm_mode)
                        next_s.compare_value = wdata_i;
                end
                `TMR_OFS_STATUS: begin
                    // flags already cleared ahead of the counting logic
                end
                default: ;
            endcase
        end

        // forced compare: output state only, no flag, no counter change
        if (force_hit) begin
            unique case (force_act)
                2'd1: next_s.compare_output_state = !next_s.compare_output_state;
                2'd2: next_s.compare_output_state = 1'b0;
                2'd3: next_s.compare_output_state = 1'b1;
                default: ;
            endcase
        end

        // read data stands only in the cycle after the strobe
        next_s.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `TMR_OFS_CTRL:   next_s.rdata = {1'b0, s.wave_mode_select[0], s.output_action_select,
                                                 s.wave_mode_select[1], s.clock_select};
                `TMR_OFS_COUNT:  next_s.rdata = s.count_value;
                `TMR_OFS_CMP:    next_s.rdata = s.compare_buf;
                `TMR_OFS_STATUS: next_s.rdata = {5'h00, s.compare_output_state,
                                                 s.compare_flag, s.overflow_flag};
                default:         next_s.rdata = 8'h00;
            endcase
        end

        // pin mux follows action select only, never wave mode
        next_s.pin_out = (next_s.output_action_select != 2'b00) ? next_s.compare_output_state : port_value_i;
        next_s.pin_oe  = compare_pin_direction_i;

        // clock enable low holds everything
        if (!core_ce_i)
            next_s = s;
    end

    // ==========================================================
    // state register
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_o   = s.rdata;
    assign pin_out_o = s.pin_out;
    assign pin_oe_o  = s.pin_oe;

    // ==========================================================
    // assertions
    property p_reset_ocs;
        @(posedge core_clk_i) reset_i |=> (s.compare_output_state == 1'b0 && pin_oe_o == 1'b0);
    endproperty
    a_reset_ocs: assert property (p_reset_ocs) else $error("output state not cleared by reset");

    property p_override;
        @(posedge core_clk_i) disable iff (reset_i)
        core_ce_i ##1 (s.output_action_select != 2'b00) |-> pin_out_o == s.compare_output_state;
    endproperty
    a_override: assert property (p_override) else $error("pin not driven from output state");

    property p_no_action;
        @(posedge core_clk_i) disable iff (reset_i)
        (s.output_action_select == 2'b00 && !(wr_i && addr_i == `TMR_OFS_CTRL))
        |=> s.compare_output_state == $past(s.compare_output_state);
    endproperty
    a_no_action: assert property (p_no_action) else $error("output state moved with action zero");

    property p_normal_wrap;
        @(posedge core_clk_i) disable iff (reset_i)
        (tick && s.wave_mode_select == TMR_WAVE_NORMAL && !wr_i && s.count_value == `TMR_MAX)
        |=> (s.count_value == `TMR_BOTTOM && s.overflow_flag);
    endproperty
    a_normal_wrap: assert property (p_normal_wrap) else $error("normal mode wrap or overflow wrong");

    property p_ctc_clear;
        @(posedge core_clk_i) disable iff (reset_i)
        (tick && s.wave_mode_select == TMR_WAVE_CLEAR_ON_MATCH && !wr_i && match)
        |=> (s.count_value == `TMR_BOTTOM && s.compare_flag);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("clear-on-match did not clear");

    property p_ctc_toggle;
        @(posedge core_clk_i) disable iff (reset_i)
        (tick && s.wave_mode_select == TMR_WAVE_CLEAR_ON_MATCH && s.output_action_select == 2'd1
         && match && !wr_i) |=> s.compare_output_state != $past(s.compare_output_state);
    endproperty
    a_ctc_toggle: assert property (p_ctc_toggle) else $error("toggle missing on match");

    property p_fpwm_ovf;
        @(posedge core_clk_i) disable iff (reset_i)
        (tick && s.wave_mode_select == TMR_WAVE_FAST_PWM && !wr_i && s.count_value == 8'hFE)
        |=> (s.count_value == `TMR_MAX && s.overflow_flag);
    endproperty
    a_fpwm_ovf: assert property (p_fpwm_ovf) else $error("fast pwm overflow not set at max");

    property p_freeze;
        @(posedge core_clk_i) disable iff (reset_i)
        !core_ce_i |=> (s.count_value == $past(s.count_value) && s.prescale == $past(s.prescale));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_count_write;
        @(posedge core_clk_i) disable iff (reset_i)
        core_ce_i && count_wr
        |=> s.count_value == $past(wdata_i);
    endproperty
    a_count_write: assert property (p_count_write) else $error("count write lost");

    property p_pin_dir;
        @(posedge core_clk_i) disable iff (reset_i)
        core_ce_i
        |=> pin_oe_o == $past(compare_pin_direction_i);
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pin direction not followed");

    property p_port_pass;
        @(posedge core_clk_i) disable iff (reset_i)
        core_ce_i ##1 (s.output_action_select == 2'b00)
        |-> pin_out_o == $past(port_value_i);
    endproperty
    a_port_pass: assert property (p_port_pass) else $error("port value not passed");

    property p_cmp_flag;
        @(posedge core_clk_i) disable iff (reset_i)
        tick && match
        |=> s.compare_flag;
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set");

    property p_ovf_sticky;
        @(posedge core_clk_i) disable iff (reset_i)
        s.overflow_flag && !(wr_i && addr_i == `TMR_OFS_STATUS)
        |=> s.overflow_flag;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

    property p_normal_step;
        @(posedge core_clk_i) disable iff (reset_i)
        tick && s.wave_mode_select == TMR_WAVE_NORMAL && !wr_i
        |=> s.count_value == $past(s.count_value) + 8'h01;
    endproperty
    a_normal_step: assert property (p_normal_step) else $error("normal mode did not step");

    property p_ctc_wrap;
        @(posedge core_clk_i) disable iff (reset_i)
        tick && s.wave_mode_select == TMR_WAVE_CLEAR_ON_MATCH && !wr_i && !match && s.count_value == `TMR_MAX
        |=> (s.count_value == `TMR_BOTTOM && s.overflow_flag);
    endproperty
    a_ctc_wrap: assert property (p_ctc_wrap) else $error("clear-on-match wrap wrong");

    property p_fpwm_wrap;
        @(posedge core_clk_i) disable iff (reset_i)
        tick && s.wave_mode_select == TMR_WAVE_FAST_PWM && !wr_i && s.count_value == `TMR_MAX
        |=> s.count_value == `TMR_BOTTOM;
    endproperty
    a_fpwm_wrap: assert property (p_fpwm_wrap) else $error("fast pwm did not restart");

    property p_fpwm_set;
        @(posedge core_clk_i) disable iff (reset_i)
        tick && s.wave_mode_select == TMR_WAVE_FAST_PWM && !wr_i && s.count_value == `TMR_MAX
        && s.output_action_select == 2'd2 |=> s.compare_output_state;
    endproperty
    a_fpwm_set: assert property (p_fpwm_set) else $error("fast pwm not set at bottom");

    property p_fpwm_reload;
        @(posedge core_clk_i) disable iff (reset_i)
        tick && s.wave_mode_select == TMR_WAVE_FAST_PWM && s.count_value == `TMR_MAX
        |=> s.compare_value == $past(s.compare_buf);
    endproperty
    a_fpwm_reload: assert property (p_fpwm_reload) else $error("compare not reloaded at top");

    property p_cmp_direct;
        @(posedge core_clk_i) disable iff (reset_i)
        core_ce_i && wr_i && addr_i == `TMR_OFS_CMP && !pwm_mode
        |=> s.compare_value == $past(wdata_i);
    endproperty
    a_cmp_direct: assert property (p_cmp_direct) else $error("compare write not immediate");

    c_ctc_toggle: cover property (@(posedge core_clk_i) disable iff (reset_i)
        tick && s.wave_mode_select == TMR_WAVE_CLEAR_ON_MATCH && match && s.output_action_select == 2'd1);
    c_fpwm_top: cover property (@(posedge core_clk_i) disable iff (reset_i)
        tick && s.wave_mode_select == TMR_WAVE_FAST_PWM && s.count_value == `TMR_MAX);
    c_force: cover property (@(posedge core_clk_i) disable iff (reset_i)
        core_ce_i && wr_i && addr_i == `TMR_OFS_CTRL && wdata_i[`TMR_CTRL_FORCE]);

endmodule

// ---- tmr_pin_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// port pin model: resolves the pad level from the block's drive
module tmr_pin_model (
    input  wire logic core_clk_i,  // system clock
    input  wire logic pin_out_i,   // value offered by the block
    input  wire logic pin_oe_i,    // drive enable from the block
    output logic      pin_level_o  // level seen on the pad
);
    logic last_q;  // last level driven

    // no pull: a released pad shows the inverse of its last driven level
    always_ff @(posedge core_clk_i) begin
        if (pin_oe_i) begin
            last_q <= pin_out_i;
        end
    end

    // pad direction comes only from the enable, never from the override
    assign pin_level_o = pin_oe_i ? pin_out_i : ~last_q;
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // one table row: setup, run length and expected results
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] act;
        logic [1:0] init;
        logic [7:0] cnt;
        logic [7:0] cmp;
        logic [8:0] ticks;
        logic [7:0] exp_cnt;
        logic [2:0] exp_stat;
    } tmr_row_s;

    localparam tmr_row_s ROWS [14] = '{
        '{2'h0, 2'h0, 2'h2, 8'hFE, 8'h10, 9'h002, 8'h00, 3'h1},
        '{2'h0, 2'h1, 2'h2, 8'h0E, 8'h10, 9'h004, 8'h12, 3'h6},
        '{2'h0, 2'h3, 2'h2, 8'h20, 8'h21, 9'h003, 8'h23, 3'h6},
        '{2'h0, 2'h2, 2'h3, 8'h30, 8'h31, 9'h002, 8'h32, 3'h2},
        '{2'h2, 2'h0, 2'h3, 8'h40, 8'h41, 9'h003, 8'h01, 3'h6},
        '{2'h2, 2'h1, 2'h2, 8'h00, 8'h02, 9'h007, 8'h01, 3'h2},
        '{2'h2, 2'h0, 2'h2, 8'hFE, 8'h05, 9'h003, 8'h01, 3'h1},
        '{2'h3, 2'h2, 2'h3, 8'h10, 8'h12, 9'h004, 8'h14, 3'h2},
        '{2'h3, 2'h2, 2'h2, 8'hFD, 8'h80, 9'h003, 8'h00, 3'h5},
        '{2'h3, 2'h3, 2'h3, 8'hFE, 8'h80, 9'h002, 8'h00, 3'h1},
        '{2'h3, 2'h2, 2'h2, 8'hFD, 8'hFF, 9'h003, 8'h00, 3'h7},
        '{2'h3, 2'h2, 2'h2, 8'hFE, 8'h00, 9'h003, 8'h01, 3'h3},
        '{2'h0, 2'h0, 2'h2, 8'h50, 8'h50, 9'h002, 8'h52, 3'h0},
        '{2'h3, 2'h2, 2'h2, 8'h00, 8'h80, 9'h100, 8'h00, 3'h7}
    };

    logic       core_clk_i;
    logic       reset_i;
    logic       core_ce_i;
    logic [2:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       port_value_i;
    logic       compare_pin_direction_i;
    logic       pin_out_o;
    logic       pin_oe_o;
    logic       pin_level;
    logic [7:0] v;
    tmr_row_s   r;
    int         failures;
    int         checked;

    tmr_wave dut_u (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .core_ce_i(core_ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_value_i(port_value_i),
        .compare_pin_direction_i(compare_pin_direction_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o)
    );

    tmr_pin_model pin_u (
        .core_clk_i(core_clk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pin_level_o(pin_level)
    );

    // ==========================================================
    // 40 MHz system clock
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    // ==========================================================
    // bus tasks: strobe dropped at the taking edge, so two calls never clash in one step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample mid-cycle there
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        @(negedge core_clk_i);
        d = rdata_o;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s: got %h want %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [7:0] ctl(logic f, logic [1:0] m, logic [1:0] a, logic [2:0] cs);
        return {f, m[0], a, m[1], cs};
    endfunction

    // start undivided, stop n edges later: the stop edge still ticks, giving exactly n ticks (n >= 2)
    task automatic run(input logic [1:0] m, input logic [1:0] a, input int n);
        wr(3'h0, ctl(1'b0, m, a, 3'h1));
        repeat (n - 2) @(posedge core_clk_i);
        wr(3'h0, ctl(1'b0, m, a, 3'h0));
    endtask

    task automatic do_reset();
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(negedge core_clk_i);
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // hang guard: whole run is well under this bound
    initial begin
        repeat (20000) @(posedge core_clk_i);
        $display("BAD %0t watchdog expired", $time);
        failures++;
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial begin
        reset_i = 1'b1;
        core_ce_i = 1'b1;
        addr_i = 3'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        port_value_i = 1'b0;
        compare_pin_direction_i = 1'b0;
        failures = 0;
        checked = 0;
        do_reset();
        chk(rdata_o, 8'h00, "read data after reset");
        chk({6'h00, pin_oe_o, pin_out_o}, 8'h00, "pin after reset");
        rd(3'h3, v);
        chk(v, 8'h00, "status after reset");
        rd(3'h5, v);
        chk(v, 8'h00, "unmapped read");
        $display("reset test done");

        // forced compare moves only the output state, and only outside pwm modes
        wr(3'h1, 8'h33);
        wr(3'h0, ctl(1'b1, 2'h0, 2'h3, 3'h0));
        rd(3'h3, v);
        chk(v, 8'h04, "force set, no flags");
        rd(3'h1, v);
        chk(v, 8'h33, "force leaves count");
        wr(3'h0, ctl(1'b1, 2'h0, 2'h1, 3'h0));
        rd(3'h3, v);
        chk(v, 8'h00, "force toggle");
        wr(3'h0, ctl(1'b1, 2'h3, 2'h3, 3'h0));
        rd(3'h3, v);
        chk(v, 8'h00, "force ignored in pwm");
        rd(3'h0, v);
        chk(v, 8'h78, "control readback, force reads zero");
        $display("force test done");

        // table rows; the port value is the opposite of the expected state so override shows
        for (int i = 0; i < 14; i++) begin
            r = ROWS[i];
            @(posedge core_clk_i);
            port_value_i <= ~r.exp_stat[2];
            compare_pin_direction_i <= ~i[0];
            wr(3'h0, ctl(1'b1, 2'h0, r.init, 3'h0));
            wr(3'h2, r.cmp);
            wr(3'h1, r.cnt);
            wr(3'h3, 8'h07);
            run(r.mode, r.act, int'(r.ticks));
            rd(3'h1, v);
            chk(v, r.exp_cnt, "row count");
            rd(3'h3, v);
            chk(v, {5'h00, r.exp_stat}, "row status");
            if (i[0] == 1'b0) begin
                chk({7'h00, pin_level}, {7'h00, (r.act != 2'h0) ? r.exp_stat[2] : ~r.exp_stat[2]}, "pin");
            end else begin
                chk({7'h00, pin_oe_o}, 8'h00, "pin released");
            end
            $display("row %0d done", i);
        end

        // pwm compare writes wait for the top; an immediate one would match at 0xFE
        wr(3'h0, ctl(1'b0, 2'h0, 2'h0, 3'h0));
        wr(3'h2, 8'h10);
        wr(3'h1, 8'hFD);
        wr(3'h3, 8'h07);
        wr(3'h0, ctl(1'b0, 2'h3, 2'h0, 3'h0));
        wr(3'h2, 8'hFE);
        rd(3'h2, v);
        chk(v, 8'hFE, "compare buffer readback");
        run(2'h3, 2'h0, 3);
        rd(3'h3, v);
        chk(v & 8'h03, 8'h01, "buffered compare");
        $display("buffer test done");

        // frozen enable stops counting: seven edges pass, only two tick
        wr(3'h1, 8'h60);
        wr(3'h0, ctl(1'b0, 2'h0, 2'h0, 3'h1));
        core_ce_i <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        core_ce_i <= 1'b1;
        wr(3'h0, ctl(1'b0, 2'h0, 2'h0, 3'h0));
        rd(3'h1, v);
        chk(v, 8'h62, "enable gating");
        // divide by 8: any sixteen ticked edges hold exactly two ticks
        wr(3'h1, 8'h00);
        wr(3'h0, ctl(1'b0, 2'h0, 2'h0, 3'h2));
        repeat (14) @(posedge core_clk_i);
        wr(3'h0, ctl(1'b0, 2'h0, 2'h0, 3'h0));
        rd(3'h1, v);
        chk(v, 8'h02, "divide by 8");
        $display("enable test done");

        // reset in mid-run clears a set output state
        wr(3'h0, ctl(1'b1, 2'h0, 2'h3, 3'h1));
        do_reset();
        rd(3'h3, v);
        chk(v, 8'h00, "state after second reset");
        $display("second reset test done");
        end_sim();
    end
endmodule
